// File: rtl/scsr_spi.sv
`timescale 1ns/1ns
`include "scsr_defines.svh"
module scsr_spi (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_sck,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_page,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_nss,
   output logic o_sck,
   output logic o_sck_oe,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_nss,
   output logic o_nss_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode, shared by the read and write paths
   function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] page,
                                    input logic [7:0] target);
      sfr_hit = (page == `SCSR_PAGE) && (addr == target);
   endfunction : sfr_hit

   // Slave shift step on the sampling edge
   function automatic scsr_pkg::scsr_link_t link_step(input scsr_pkg::scsr_link_t l,
                                                       input logic d);
      return '{sh: {l.sh[6:0], d}, cnt: 3'(l.cnt + 3'h1)};
   endfunction : link_step

   scsr_pkg::scsr_regs_t r;
   scsr_pkg::scsr_regs_t n;
   scsr_pkg::scsr_link_t lp;
   scsr_pkg::scsr_link_t ln;
   scsr_pkg::scsr_link_t next_lp;
   scsr_pkg::scsr_link_t next_ln;
   logic tog_p, tog_n, next_tog_p, next_tog_n;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [7:0] next_rdata;
   logic samp_pos;
   logic link_rst_n;
   logic [7:0] link_sh;
   logic [2:0] link_cnt;
   logic sck_s, miso_s, nss_s, tog_s;
   logic slave_on;
   logic mm_mode;
   logic wr_ctl, wr_cfg, wr_ckr, wr_dat, rd_dat;
   logic sck_lead;
   logic rx_done;
   logic [7:0] m_rx;

   ////////////////////////////////////////////////////////////////////////
   // Link-clock domain: slave shift and bit count
   // Sampling edge is the leading edge for phase 0, trailing for phase 1
   assign samp_pos = (r.clock_polarity == r.clock_phase);
   assign mm_mode = (r.mode == `SCSR_MODE_MM);
   // Raw select high restarts the bit counter in multi-master mode, as does disabling the unit
   assign link_rst_n = i_arst_n & r.interface_enable & ~r.master_enable & ~(mm_mode & i_nss);

   // Next values for both edge halves
   always_comb begin
      next_lp = lp;
      next_ln = ln;
      next_tog_p = tog_p;
      next_tog_n = tog_n;
      if (samp_pos) begin
         next_lp = link_step(lp, i_mosi);
         next_tog_p = tog_p ^ (lp.cnt == `SCSR_LAST_BIT);
      end else begin
         next_ln = link_step(ln, i_mosi);
         next_tog_n = tog_n ^ (ln.cnt == `SCSR_LAST_BIT);
      end
   end

   // Rising-edge half
   always_ff @(posedge i_sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lp <= '0;
      end else begin
         lp <= next_lp;
      end
   end

   // Falling-edge half
   always_ff @(negedge i_sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ln <= '0;
      end else begin
         ln <= next_ln;
      end
   end

   // Byte-done toggles; kept out of the counter reset so no false event
   always_ff @(posedge i_sck or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tog_p <= 1'b0;
      end else begin
         tog_p <= next_tog_p;
      end
   end

   always_ff @(negedge i_sck or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tog_n <= 1'b0;
      end else begin
         tog_n <= next_tog_n;
      end
   end

   assign {link_sh, link_cnt} = samp_pos ? lp : ln;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for pins and the byte-done toggle
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1 <= `SCSR_SYNC_RST;
         sync2 <= `SCSR_SYNC_RST;
      end else begin
         sync1 <= {tog_p ^ tog_n, i_nss, i_miso, i_sck};
         sync2 <= sync1;
      end
   end

   assign {tog_s, nss_s, miso_s, sck_s} = sync2;

   ////////////////////////////////////////////////////////////////////////
   // Register access strobes
   assign wr_ctl = i_sfr_wr & sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_CTL_ADDR);
   assign wr_cfg = i_sfr_wr & sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_CFG_ADDR);
   assign wr_ckr = i_sfr_wr & sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_CKR_ADDR);
   assign wr_dat = i_sfr_wr & sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_DAT_ADDR);
   assign rd_dat = i_sfr_rd & sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_DAT_ADDR);
   assign slave_on = r.interface_enable & ~r.master_enable;
   // Leaving the idle level starts each bit; return edges are ignored
   assign sck_lead = (sck_s ^ r.sck_d) & (sck_s != r.clock_polarity);
   assign rx_done = tog_s ^ r.tog_d;
   assign m_rx = {r.shreg[6:0], miso_s};

   ////////////////////////////////////////////////////////////////////////
   // System-domain next state; later assignments win, so hardware sets
   // placed after software writes beat a clear in the same cycle
   always_comb begin
      n = r;
      n.sck_d = sck_s;
      n.tog_d = tog_s;
      n.nss_hist = {r.nss_hist[0], nss_s};
      // Three equal samples in a row before the flag moves
      if (r.nss_hist == {2{nss_s}}) begin
         n.slave_selected_flag = ~nss_s;
      end
      if (wr_ctl) begin
         n.spif = i_sfr_wdata[`SCSR_B_SPIF];
         n.wcol = i_sfr_wdata[`SCSR_B_WCOL];
         n.mode_fault_flag = i_sfr_wdata[`SCSR_B_MODE_FAULT_FLAG];
         n.rxovrn = i_sfr_wdata[`SCSR_B_RXOVRN];
         n.mode = i_sfr_wdata[`SCSR_B_MODE_HI:`SCSR_B_MODE_LO];
         n.interface_enable = i_sfr_wdata[`SCSR_B_INTERFACE_ENABLE];
      end
      // Only the three control bits take a write; status bits are derived
      if (wr_cfg) begin
         n.master_enable = i_sfr_wdata[`SCSR_B_MASTER_ENABLE];
         n.clock_phase = i_sfr_wdata[`SCSR_B_CPHA];
         n.clock_polarity = i_sfr_wdata[`SCSR_B_CPOL];
      end
      if (wr_ckr) begin
         n.ckr = i_sfr_wdata;
      end
      // Double-buffered transmit; a write into a full buffer is dropped
      if (wr_dat) begin
         if (r.tx_full) begin
            n.wcol = 1'b1;
         end else begin
            n.tx_buf = i_sfr_wdata;
            n.tx_full = 1'b1;
         end
      end
      if (rd_dat) begin
         n.rx_full = 1'b0;
      end
      // Slave role
      if (slave_on) begin
         if (sck_lead & ~(mm_mode & nss_s)) begin // Traffic for other slaves ignored
            n.shift_reg_empty = 1'b0;
            n.sbusy = 1'b1;
         end
         if (rx_done) begin
            n.sbusy = 1'b0;
            n.spif = 1'b1;
            n.shift_reg_empty = 1'b1;
            if (r.rx_full) begin
               n.rxovrn = 1'b1;
            end else begin
               n.rx_buf = link_sh;
               n.rx_full = 1'b1;
            end
         end
         if ((r.shift_reg_empty | rx_done) & r.tx_full) begin
            n.shreg = r.tx_buf;
            n.tx_full = 1'b0;
            n.shift_reg_empty = 1'b0;
         end
      end
      // Deselect in multi-master mode ends a cut frame; a disabled slave is never busy
      if (~slave_on | (mm_mode & nss_s)) begin
         n.sbusy = 1'b0;
      end
      // Master role: half-period divider from the clock-rate register
      case (r.mst)
         scsr_pkg::MST_IDLE: begin
            if (r.interface_enable & r.master_enable & r.tx_full) begin
               n.shreg = r.tx_buf;
               n.tx_full = 1'b0;
               n.mst = scsr_pkg::MST_SHIFT;
               n.hcnt = r.ckr;
               n.half = 1'b0;
               n.bcnt = 3'h0;
            end
         end
         scsr_pkg::MST_SHIFT: begin
            if (r.hcnt != 8'h00) begin
               n.hcnt = 8'(r.hcnt - 8'h01);
            end else begin
               n.hcnt = r.ckr;
               n.half = ~r.half;
               // Last cycle of the bit: latest sample, most settling time
               if (r.half) begin
                  n.shreg = m_rx;
                  n.bcnt = 3'(r.bcnt + 3'h1);
                  if (r.bcnt == `SCSR_LAST_BIT) begin
                     n.mst = scsr_pkg::MST_IDLE;
                     n.spif = 1'b1;
                     n.rx_buf = m_rx;
                     n.rx_full = 1'b1;
                  end
               end
            end
         end
         default: begin
            n.mst = scsr_pkg::MST_IDLE;
         end
      endcase
      if (~r.interface_enable | ~r.master_enable) begin
         n.mst = scsr_pkg::MST_IDLE;
      end
      // Another master pulled select low
      if (mm_mode & r.master_enable & ~nss_s) begin
         n.master_enable = 1'b0;
         n.interface_enable = 1'b0;
         n.mode_fault_flag = 1'b1;
         n.mst = scsr_pkg::MST_IDLE;
      end
   end

   // System-domain registers
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '0;
         r.mode <= `SCSR_MODE_RST;
         r.shift_reg_empty <= 1'b1;
         r.nss_hist <= 2'h3;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, registered one cycle after the read strobe
   always_comb begin
      next_rdata = 8'h00;
      if (i_sfr_rd) begin
         if (sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_CFG_ADDR)) begin
            next_rdata[`SCSR_B_BUSY] = r.sbusy | (r.mst == scsr_pkg::MST_SHIFT);
            next_rdata[`SCSR_B_MASTER_ENABLE] = r.master_enable;
            next_rdata[`SCSR_B_CPHA] = r.clock_phase;
            next_rdata[`SCSR_B_CPOL] = r.clock_polarity;
            next_rdata[`SCSR_B_SLAVE_SELECTED_FLAG] = r.slave_selected_flag;
            next_rdata[`SCSR_B_SELECT_PIN_RAW] = nss_s;
            next_rdata[`SCSR_B_SHIFT_REG_EMPTY] = r.master_enable | r.shift_reg_empty;
            next_rdata[`SCSR_B_RX_BUFFER_EMPTY] = r.master_enable | ~r.rx_full;
         end else if (sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_CTL_ADDR)) begin
            next_rdata = {r.spif, r.wcol, r.mode_fault_flag, r.rxovrn, r.mode, ~r.tx_full, r.interface_enable};
         end else if (sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_CKR_ADDR)) begin
            next_rdata = r.ckr;
         end else if (sfr_hit(i_sfr_addr, i_sfr_page, `SCSR_DAT_ADDR)) begin
            next_rdata = r.rx_buf;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sfr_rdata <= 8'h00;
      end else begin
         o_sfr_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers
   // Master clock idles at polarity; phase picks which half is active
   assign o_sck = r.clock_polarity ^ ((r.mst == scsr_pkg::MST_SHIFT) & (r.half ^ r.clock_phase));
   assign o_sck_oe = r.interface_enable & r.master_enable;
   assign o_mosi = r.shreg[7];
   assign o_mosi_oe = r.interface_enable & r.master_enable;
   // Slave output bit follows the link counter; it reads a stable byte
   assign o_miso = r.shreg[3'(`SCSR_LAST_BIT - link_cnt)];
   assign o_miso_oe = slave_on & ((r.mode == `SCSR_MODE_3W) | ~nss_s);
   assign o_nss = r.mode[0];
   assign o_nss_oe = r.mode[1];
endmodule : scsr_spi

// File: include/scsr_defines.svh
`ifndef SCSR_DEFINES_SVH
`define SCSR_DEFINES_SVH
// Special-function addresses, all on one page
`define SCSR_PAGE 8'h00
`define SCSR_CFG_ADDR 8'ha1
`define SCSR_CKR_ADDR 8'ha2
`define SCSR_DAT_ADDR 8'ha3
`define SCSR_CTL_ADDR 8'hf8
// Config/status bit positions
`define SCSR_B_BUSY 7
`define SCSR_B_MASTER_ENABLE 6
`define SCSR_B_CPHA 5
`define SCSR_B_CPOL 4
`define SCSR_B_SLAVE_SELECTED_FLAG 3
`define SCSR_B_SELECT_PIN_RAW 2
`define SCSR_B_SHIFT_REG_EMPTY 1
`define SCSR_B_RX_BUFFER_EMPTY 0
// Control bit positions
`define SCSR_B_SPIF 7
`define SCSR_B_WCOL 6
`define SCSR_B_MODE_FAULT_FLAG 5
`define SCSR_B_RXOVRN 4
`define SCSR_B_MODE_HI 3
`define SCSR_B_MODE_LO 2
`define SCSR_B_TXBMT 1
`define SCSR_B_INTERFACE_ENABLE 0
// Reset values
`define SCSR_CFG_RST 8'h07
`define SCSR_MODE_RST 2'h1
`define SCSR_SYNC_RST 4'h4
// Select mode codes
`define SCSR_MODE_3W 2'h0
`define SCSR_MODE_MM 2'h1
// Last bit index of a byte
`define SCSR_LAST_BIT 3'h7
`endif

// File: include/scsr_pkg.sv
package scsr_pkg;
   typedef enum logic [0:0] {
      MST_IDLE = 1'b0,
      MST_SHIFT = 1'b1
   } scsr_mst_t;
   // System-domain state of the unit
   typedef struct packed {
      logic spif;
      logic wcol;
      logic mode_fault_flag;
      logic rxovrn;
      logic [1:0] mode;
      logic interface_enable;
      logic master_enable;
      logic clock_phase;
      logic clock_polarity;
      logic [7:0] ckr;
      logic [7:0] tx_buf;
      logic [7:0] rx_buf;
      logic [7:0] shreg;
      logic tx_full;
      logic rx_full;
      logic shift_reg_empty;
      logic sbusy;
      scsr_mst_t mst;
      logic [7:0] hcnt;
      logic half;
      logic [2:0] bcnt;
      logic [1:0] nss_hist;
      logic slave_selected_flag;
      logic sck_d;
      logic tog_d;
   } scsr_regs_t;
   // Slave shift state on the link clock
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] cnt;
   } scsr_link_t;
endpackage : scsr_pkg

// File: sim/scsr_spi_monitor.sv
`timescale 1ns/1ns
// Port-level watch on the serial config/status unit
module scsr_spi_monitor (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_page,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic i_nss,
   input wire logic o_sck_oe,
   input wire logic o_mosi_oe,
   input wire logic o_miso_oe,
   input wire logic o_nss,
   input wire logic o_nss_oe
);
   logic nss_q;
   logic [3:0] nss_same;
   logic cfg_rd;
   logic ctl_wr;
   logic wd_hi;
   logic wd_lo;
   ////////////////////////////////////////////////////////////////
   // Quiet time of the select pin; the de-glitcher needs several cycles
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         nss_q <= 1'b1;
         nss_same <= 4'h0;
      end else begin
         nss_q <= i_nss;
         nss_same <= (i_nss != nss_q) ? 4'h0 : ((nss_same == 4'hf) ? nss_same : nss_same + 4'h1);
      end
   end
   // Decoded accesses
   assign cfg_rd = i_sfr_rd && i_sfr_addr == 8'ha1 && i_sfr_page == 8'h00;
   assign ctl_wr = i_sfr_wr && i_sfr_addr == 8'hf8 && i_sfr_page == 8'h00;
   assign wd_hi = i_sfr_wdata[3];
   assign wd_lo = i_sfr_wdata[2];
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   AST_RD_IDLE: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
      else $error("read data not zero without a read");
   AST_OFF_PAGE: assert property (i_sfr_rd && i_sfr_page != 8'h00 |=> o_sfr_rdata == 8'h00)
      else $error("access on another page answered");
   AST_RAW_SELECT: assert property (cfg_rd && nss_same > 4'ha |=> o_sfr_rdata[2] == $past(i_nss))
      else $error("raw select bit wrong");
   AST_SELECTED: assert property (cfg_rd && nss_same > 4'ha |=> o_sfr_rdata[3] == !$past(i_nss))
      else $error("selected flag wrong");
   AST_MASTER_FLAGS: assert property (cfg_rd ##1 o_sfr_rdata[6] |-> o_sfr_rdata[1:0] == 2'b11)
      else $error("empty flags low in master role");
   AST_ROLE_OE: assert property (o_sck_oe |-> !o_miso_oe)
      else $error("master and slave drivers both on");
   AST_MOSI_OE: assert property (o_mosi_oe == o_sck_oe)
      else $error("master data enable apart from clock enable");
   AST_NSS_MODE: assert property (ctl_wr |-> ##2 o_nss_oe == $past(wd_hi, 2))
      else $error("select output enable not per mode");
   AST_NSS_LEVEL: assert property (ctl_wr && wd_hi |-> ##2 o_nss == $past(wd_lo, 2))
      else $error("select output level not per mode");
endmodule : scsr_spi_monitor
bind scsr_spi scsr_spi_monitor u_mon (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_sfr_addr(i_sfr_addr),
   .i_sfr_page(i_sfr_page), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
   .o_sfr_rdata(o_sfr_rdata), .i_nss(i_nss), .o_sck_oe(o_sck_oe), .o_mosi_oe(o_mosi_oe),
   .o_miso_oe(o_miso_oe), .o_nss(o_nss), .o_nss_oe(o_nss_oe));

// File: sim/scsr_peer.sv
`timescale 1ns/1ns
// Far device: frames bytes as a master, answers as a slave, mode 0
module scsr_peer (
   input wire logic i_msck,
   input wire logic i_mmosi,
   input wire logic i_smiso,
   output logic o_sck,
   output logic o_mosi,
   output logic o_nss,
   output logic o_miso
);
   logic [7:0] rx;
   logic [7:0] sl_sh;
   ////////////////////////////////////////////////////////////////
   // Idle: clock low, not selected
   initial begin
      o_sck = 1'b0;
      o_mosi = 1'b0;
      o_nss = 1'b1;
      o_miso = 1'b0;
      rx = 8'h00;
      sl_sh = 8'h00;
   end
   // Select level, low selects
   task sel(input logic v);
      o_nss = v;
   endtask : sel
   // One byte at 64 ns per bit; clock stands still outside the frame
   task send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_mosi = b[i];
         #32;
         rx = {rx[6:0], i_smiso};
         o_sck = 1'b1;
         #32;
         o_sck = 1'b0;
      end
      o_mosi = ~o_mosi; // Released line shows no stale bit
   endtask : send
   // Slave side: first bit out before the first edge
   task arm(input logic [7:0] b);
      sl_sh = b;
      o_miso = b[7];
   endtask : arm
   // Capture on leading edge, shift on trailing edge
   always @(posedge i_msck) rx = {rx[6:0], i_mmosi};
   always @(negedge i_msck) begin
      sl_sh = {sl_sh[6:0], ~sl_sh[7]};
      o_miso = sl_sh[7];
   end
endmodule : scsr_peer

// File: sim/tb.sv
`timescale 1ns/1ns
// Self-checking bench for the serial config/status unit
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] page = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [7:0] r;
   logic sck, sck_oe, mosi, mosi_oe, miso, miso_oe, slave_select_pin, nss_oe;
   logic p_sck, p_mosi, p_nss, p_miso;
   int fail_count = 0;
   int compares = 0;
   // Config write beside expected read-back, select pin high
   logic [15:0] rows [4] = '{16'h7077, 16'hff77, 16'h3037, 16'h0007};
   ////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;
   scsr_spi DUT (.i_ref_clk(clk), .i_arst_n(rst_n), .i_sck(p_sck), .i_sfr_addr(addr), .i_sfr_page(page),
      .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_mosi(p_mosi),
      .i_miso(p_miso), .i_nss(p_nss), .o_sck(sck), .o_sck_oe(sck_oe), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
      .o_miso(miso), .o_miso_oe(miso_oe), .o_nss(slave_select_pin), .o_nss_oe(nss_oe));
   scsr_peer PEER (.i_msck(sck), .i_mmosi(mosi), .i_smiso(miso), .o_sck(p_sck), .o_mosi(p_mosi),
      .o_nss(p_nss), .o_miso(p_miso));
   ////////////////////////////////////////////////////////////////
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask : chk
   // One-cycle strobes, driven just after the edge
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #2;
      wr = 1'b0;
   endtask : wr_reg
   // Read data stands only one cycle, so take it right away
   task rd_reg(input logic [7:0] a);
      @(posedge clk);
      #2;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #2;
      rd = 1'b0;
      r = rdata;
   endtask : rd_reg
   task report_and_stop;
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the expected few microseconds
   initial begin
      #100000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      repeat (2) @(posedge clk);
      #2;
      rst_n = 1'b1;
      rd_reg(8'ha1);
      chk("cfg reset", 8'h07, r);
      page = 8'h01;
      rd_reg(8'ha1);
      chk("other page", 8'h00, r);
      page = 8'h00;
      foreach (rows[k]) begin
         wr_reg(8'ha1, rows[k][15:8]);
         rd_reg(8'ha1);
         chk("cfg row", rows[k][7:0], r);
      end
      // Slave role, four-wire, one byte each way
      wr_reg(8'hf8, 8'h05);
      PEER.sel(1'b0);
      repeat (12) @(posedge clk);
      rd_reg(8'ha1);
      chk("selected", 8'h0b, r);
      wr_reg(8'ha3, 8'h3c);
      rd_reg(8'ha1);
      chk("loaded", 8'h09, r);
      fork
         PEER.send(8'ha5);
         begin
            #250;
            rd_reg(8'ha1);
            chk("slave busy", 8'h80, r & 8'h82);
         end
      join
      repeat (10) @(posedge clk);
      rd_reg(8'ha1);
      chk("slave done", 8'h0a, r);
      rd_reg(8'ha3);
      chk("slave rx", 8'ha5, r);
      chk("slave tx", 8'h3c, PEER.rx);
      rd_reg(8'ha1);
      chk("rx drained", 8'h0b, r);
      // Second byte left unread, third one overruns it
      PEER.send(8'h5a);
      repeat (6) @(posedge clk);
      PEER.send(8'h69);
      repeat (6) @(posedge clk);
      rd_reg(8'hf8);
      chk("overrun ctl", 8'h97, r);
      rd_reg(8'ha3);
      chk("kept byte", 8'h5a, r);
      // Frame cut short by select; busy must drop
      fork
         PEER.send(8'hff);
         begin
            #200;
            PEER.sel(1'b1);
         end
      join
      repeat (10) @(posedge clk);
      rd_reg(8'ha1);
      chk("cut frame", 8'h05, r);
      // Master role, single-master select out, eight cycles a half bit
      wr_reg(8'hf8, 8'h08);
      wr_reg(8'ha1, 8'h40);
      wr_reg(8'ha2, 8'h07);
      wr_reg(8'hf8, 8'h09);
      chk("select out", 8'h02, {6'h00, nss_oe, slave_select_pin});
      PEER.arm(8'hc3);
      wr_reg(8'ha3, 8'h96);
      repeat (20) @(posedge clk);
      rd_reg(8'ha1);
      chk("master busy", 8'hc7, r);
      repeat (160) @(posedge clk);
      rd_reg(8'ha1);
      chk("master idle", 8'h47, r);
      rd_reg(8'ha3);
      chk("master rx", 8'hc3, r);
      chk("master tx", 8'h96, PEER.rx);
      // Unit disabled before the polarity change
      wr_reg(8'hf8, 8'h08);
      wr_reg(8'ha1, 8'h50);
      wr_reg(8'hf8, 8'h09);
      chk("idle clock", 8'h03, {6'h00, sck_oe, sck});
      // Second reset mid-run, then a collision in multi-master mode
      rst_n = 1'b0;
      @(posedge clk);
      #2;
      rst_n = 1'b1;
      rd_reg(8'hf8);
      chk("ctl reset", 8'h06, r);
      wr_reg(8'ha1, 8'h40);
      wr_reg(8'hf8, 8'h05);
      PEER.sel(1'b0);
      repeat (12) @(posedge clk);
      rd_reg(8'ha1);
      chk("fault cfg", 8'h0b, r);
      rd_reg(8'hf8);
      chk("fault ctl", 8'h26, r);
      report_and_stop;
   end
endmodule : tb
